// File: rtl/acb_top.v
// converter control: done flag, sample counting, scan list, result pointer, pin gating
// Overview of operation
// [R1] interrupt flag rises after the count chosen by samples_per_interrupt
// [R2] with scanning on, scan list restarts at first selected channel at count
// [R3] without dma the result pointer returns to buffer zero at count
// [R4] without dma sixteen buffers hold successive results in order
// [R5] buffer choice follows the pointer only, never the converted channel
// [R6] with dma one buffer, overwritten by each completed conversion
// [R7] reader must take each single-buffer result before the next completes
// [R8] hardware clears done only when a conversion starts
// [R9] done sets on completion and stays set until software clears it or the next conversion begins
// [R10] in manual sampling software clears done before setting sample start
// [R11] software sets pin digital config in both converters for digital use
// [R12] pin not digital in both: input buffer disabled, input reads zero
// [R13] result stored and pointer advanced in the cycle done sets
// [R14] field value n means n plus one conversions per interrupt
`timescale 1ns/1ps
`include "acb_regs.vh"
module acb_top #(
    parameter RES_W = 12,
    parameter NUM_PINS = 13,
    parameter HAS_DMA = 0,
    parameter DUAL_ADC = 1
) (
    input wire ref_clk,
    input wire reset_n,
    input wire [`ACB_ADDR_W-1:0] reg_addr,
    input wire [`ACB_DATA_W-1:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [`ACB_DATA_W-1:0] reg_rdata_q,
    input wire conv_start,
    input wire conv_done,
    input wire [RES_W-1:0] conv_result,
    input wire [`ACB_CH_W-1:0] conv_channel,
    output reg converter_on_q,
    output reg sample_req_q,
    output reg [`ACB_CH_W-1:0] scan_channel_q,
    input wire [NUM_PINS-1:0] partner_pin_config,
    output reg [NUM_PINS-1:0] pin_config_q,
    input wire [NUM_PINS-1:0] pad_in,
    output reg [NUM_PINS-1:0] dig_in_q,
    output reg [NUM_PINS-1:0] dig_buf_en_q,
    output reg irq_q
);
    // register decode
    wire wr_c1 = reg_wr && (reg_addr == `ACB_OFF_CTRL_ONE);
    wire wr_c2 = reg_wr && (reg_addr == `ACB_OFF_CTRL_TWO);
    wire wr_slo = reg_wr && (reg_addr == `ACB_OFF_SCAN_LOW);
    wire wr_shi = reg_wr && (reg_addr == `ACB_OFF_SCAN_HIGH);
    wire wr_pcfg = reg_wr && (reg_addr == `ACB_OFF_PIN_CFG);
    wire wr_ien = reg_wr && (reg_addr == `ACB_OFF_INT_ENABLE);
    wire wr_iclr = reg_wr && (reg_addr == `ACB_OFF_INT_CLEAR);
    wire in_result = (reg_addr[7:6] == `ACB_RESULT_REGION);
    wire [`ACB_PTR_W-1:0] rd_idx = reg_addr[5:2];
    wire rd_buf0 = reg_rd && in_result && (rd_idx == `ACB_RST_PTR);

    reg done_q;
    reg scan_en_q;
    reg [3:0] spi_q;
    reg [15:0] scan_low_q;
    reg [15:0] scan_high_q;
    reg [`ACB_EV_W-1:0] int_status_q;
    reg [`ACB_EV_W-1:0] int_enable_q;
    reg [`ACB_PTR_W-1:0] buf_ptr_q;
    reg [3:0] smp_cnt_q;
    reg unread_q;
    reg [NUM_PINS-1:0] pad_meta_q;
    reg [NUM_PINS-1:0] pad_sync_q;

    // sample counting
    wire count_hit = conv_done && (smp_cnt_q == spi_q); // [R14]
    wire overrun = conv_done && unread_q && (HAS_DMA != 0);

    // scan list search
    wire [`ACB_NUM_CH-1:0] scan_sel = {scan_high_q, scan_low_q};
    reg [`ACB_CH_W-1:0] first_ch;
    reg [`ACB_CH_W-1:0] next_ch;
    reg found_next;
    integer i;
    always @* begin
        first_ch = `ACB_RST_CH;
        next_ch = `ACB_RST_CH;
        found_next = 1'b0;
        for (i = `ACB_NUM_CH - 1; i >= 0; i = i - 1) begin
            if (scan_sel[i]) begin
                first_ch = i[`ACB_CH_W-1:0];
            end
        end
        for (i = `ACB_NUM_CH - 1; i >= 0; i = i - 1) begin
            if (scan_sel[i] && (i[`ACB_CH_W-1:0] > scan_channel_q)) begin
                next_ch = i[`ACB_CH_W-1:0];
                found_next = 1'b1;
            end
        end
        if (!found_next) begin
            next_ch = first_ch;
        end
    end

    // result storage, written only at the pointer
    wire [RES_W-1:0] buf_rd_w;
    acb_result_store #(
        .RES_W(RES_W),
        .NUM_BUF(`ACB_NUM_BUF),
        .IDX_W(`ACB_PTR_W)
    ) u_store (
        .clk(ref_clk),
        .reset_n(reset_n),
        .wr_en(conv_done),
        .wr_idx(buf_ptr_q),
        .wr_data(conv_result),
        .rd_idx(rd_idx),
        .rd_data(buf_rd_w)
    ); // [R5] [R13]

    // conv_channel is deliberately unused for buffer choice
    wire unused_ch = |conv_channel;

    // control one: on, sample start, done
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            converter_on_q <= 1'b0;
            sample_req_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            if (wr_c1) begin
                converter_on_q <= reg_wdata[`ACB_C1_ON];
            end
            // software set of sample start beats the hardware clear
            if (wr_c1 && reg_wdata[`ACB_C1_SAMPLE]) begin
                sample_req_q <= 1'b1;
            end else if (conv_start || (wr_c1 && !reg_wdata[`ACB_C1_SAMPLE])) begin
                sample_req_q <= 1'b0;
            end
            // completion wins over any clear in the same cycle
            if (conv_done) begin
                done_q <= 1'b1; // [R9]
            end else if (conv_start) begin
                done_q <= 1'b0; // [R8]
            end else if (wr_c1 && !reg_wdata[`ACB_C1_DONE]) begin
                done_q <= 1'b0; // [R10]
            end
        end
    end

    // control two, scan selects, pin config, enables
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            scan_en_q <= 1'b0;
            spi_q <= 4'h0;
            scan_low_q <= `ACB_RST_16;
            scan_high_q <= `ACB_RST_16;
            pin_config_q <= {NUM_PINS{1'b0}};
            int_enable_q <= `ACB_RST_EV;
        end else begin
            if (wr_c2) begin
                scan_en_q <= reg_wdata[`ACB_C2_SCAN];
                spi_q <= reg_wdata[`ACB_C2_SPI_HI:`ACB_C2_SPI_LO];
            end
            if (wr_slo) begin
                scan_low_q <= reg_wdata;
            end
            if (wr_shi) begin
                scan_high_q <= reg_wdata;
            end
            if (wr_pcfg) begin
                pin_config_q <= reg_wdata[NUM_PINS-1:0]; // [R11]
            end
            if (wr_ien) begin
                int_enable_q <= reg_wdata[`ACB_EV_W-1:0];
            end
        end
    end

    // sample counter, pointer and scan position
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            smp_cnt_q <= 4'h0;
            buf_ptr_q <= `ACB_RST_PTR;
            scan_channel_q <= `ACB_RST_CH;
        end else begin
            if (count_hit) begin
                smp_cnt_q <= 4'h0; // [R14]
            end else if (conv_done) begin
                smp_cnt_q <= smp_cnt_q + 4'h1;
            end
            if (HAS_DMA != 0) begin
                buf_ptr_q <= `ACB_RST_PTR; // [R6]
            end else if (count_hit) begin
                buf_ptr_q <= `ACB_RST_PTR; // [R3]
            end else if (conv_done) begin
                buf_ptr_q <= buf_ptr_q + 4'h1; // [R4] [R13]
            end
            // scan list disabled parks the selection on channel zero
            if (!scan_en_q) begin
                scan_channel_q <= `ACB_RST_CH;
            end else if (count_hit) begin
                scan_channel_q <= first_ch; // [R2]
            end else if (conv_done) begin
                scan_channel_q <= next_ch;
            end
        end
    end

    // unread tracking for the single buffer; reader keeps pace or loses data
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            unread_q <= 1'b0;
        end else if (conv_done) begin
            unread_q <= 1'b1; // [R7]
        end else if (rd_buf0) begin
            unread_q <= 1'b0;
        end
    end

    // sticky status, set beats clear
    wire [`ACB_EV_W-1:0] events = {overrun, count_hit};
    wire [`ACB_EV_W-1:0] clr_mask = wr_iclr ? reg_wdata[`ACB_EV_W-1:0] : `ACB_RST_EV;
    wire [`ACB_EV_W-1:0] status_d = (int_status_q & ~clr_mask) | events;
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            int_status_q <= `ACB_RST_EV;
            irq_q <= 1'b0;
        end else begin
            int_status_q <= status_d; // [R1]
            irq_q <= |(status_d & int_enable_q); // [R1]
        end
    end

    // pad inputs are asynchronous: two flops before the gate
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pad_meta_q <= {NUM_PINS{1'b0}};
            pad_sync_q <= {NUM_PINS{1'b0}};
        end else begin
            pad_meta_q <= pad_in;
            pad_sync_q <= pad_meta_q;
        end
    end

    // digital use needs both converters to agree
    wire [NUM_PINS-1:0] digital_ok = (DUAL_ADC != 0) ?
        (pin_config_q & partner_pin_config) : pin_config_q;
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            dig_buf_en_q <= {NUM_PINS{1'b0}};
            dig_in_q <= {NUM_PINS{1'b0}};
        end else begin
            dig_buf_en_q <= digital_ok; // [R12]
            dig_in_q <= pad_sync_q & digital_ok; // [R12]
        end
    end

    // read data one cycle after the strobe, zero elsewhere
    reg [`ACB_DATA_W-1:0] rd_mux;
    always @* begin
        rd_mux = `ACB_RST_16;
        if (in_result) begin
            if ((HAS_DMA == 0) || (rd_idx == `ACB_RST_PTR)) begin
                rd_mux[RES_W-1:0] = buf_rd_w;
            end
        end else begin
            case (reg_addr)
                `ACB_OFF_CTRL_ONE: begin
                    rd_mux[`ACB_C1_ON] = converter_on_q;
                    rd_mux[`ACB_C1_SAMPLE] = sample_req_q;
                    rd_mux[`ACB_C1_DONE] = done_q;
                end
                `ACB_OFF_CTRL_TWO: begin
                    rd_mux[`ACB_C2_SCAN] = scan_en_q;
                    rd_mux[`ACB_C2_SPI_HI:`ACB_C2_SPI_LO] = spi_q;
                end
                `ACB_OFF_SCAN_LOW: begin
                    rd_mux = scan_low_q;
                end
                `ACB_OFF_SCAN_HIGH: begin
                    rd_mux = scan_high_q;
                end
                `ACB_OFF_PIN_CFG: begin
                    rd_mux[NUM_PINS-1:0] = pin_config_q;
                end
                `ACB_OFF_INT_STATUS: begin
                    rd_mux[`ACB_EV_W-1:0] = int_status_q;
                end
                `ACB_OFF_INT_ENABLE: begin
                    rd_mux[`ACB_EV_W-1:0] = int_enable_q;
                end
                `ACB_OFF_PTR_STATUS: begin
                    rd_mux[`ACB_PTR_W-1:0] = buf_ptr_q;
                    rd_mux[11:8] = smp_cnt_q;
                    rd_mux[12] = unused_ch & 1'b0;
                end
                default: begin
                    rd_mux = `ACB_RST_16;
                end
            endcase
        end
    end

    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata_q <= `ACB_RST_16;
        end else if (reg_rd) begin
            reg_rdata_q <= rd_mux;
        end else begin
            reg_rdata_q <= `ACB_RST_16;
        end
    end
endmodule

// File: rtl/acb_regs.vh
// register offsets, field positions, reset values and sizes of the converter control block
`ifndef ACB_REGS_VH
`define ACB_REGS_VH

`define ACB_ADDR_W 8
`define ACB_DATA_W 16

`define ACB_OFF_CTRL_ONE 8'h00
`define ACB_OFF_CTRL_TWO 8'h04
`define ACB_OFF_SCAN_LOW 8'h08
`define ACB_OFF_SCAN_HIGH 8'h0c
`define ACB_OFF_PIN_CFG 8'h10
`define ACB_OFF_INT_STATUS 8'h14
`define ACB_OFF_INT_ENABLE 8'h18
`define ACB_OFF_INT_CLEAR 8'h1c
`define ACB_OFF_PTR_STATUS 8'h20
`define ACB_OFF_RESULT_BASE 8'h40

`define ACB_RESULT_REGION 2'h1

`define ACB_C1_DONE 0
`define ACB_C1_SAMPLE 1
`define ACB_C1_ON 15

`define ACB_C2_SPI_LO 2
`define ACB_C2_SPI_HI 5
`define ACB_C2_SCAN 10

`define ACB_EV_COUNT 0
`define ACB_EV_OVERRUN 1
`define ACB_EV_W 2

`define ACB_NUM_BUF 16
`define ACB_PTR_W 4
`define ACB_CH_W 5
`define ACB_NUM_CH 32

`define ACB_RST_16 16'h0000
`define ACB_RST_EV 2'h0
`define ACB_RST_PTR 4'h0
`define ACB_RST_CH 5'h00

`endif

// File: rtl/acb_result_store.v
// flip-flop result buffers, written by pointer and read by index
`timescale 1ns/1ps
module acb_result_store #(
    parameter RES_W = 12,
    parameter NUM_BUF = 16,
    parameter IDX_W = 4
) (
    input wire clk,
    input wire reset_n,
    input wire wr_en,
    input wire [IDX_W-1:0] wr_idx,
    input wire [RES_W-1:0] wr_data,
    input wire [IDX_W-1:0] rd_idx,
    output wire [RES_W-1:0] rd_data
);
    wire [RES_W*NUM_BUF-1:0] flat_w;

    genvar g;
    generate
        for (g = 0; g < NUM_BUF; g = g + 1) begin : entry
            reg [RES_W-1:0] word_q;
            always @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    word_q <= {RES_W{1'b0}};
                end else if (wr_en && (wr_idx == g)) begin
                    word_q <= wr_data;
                end
            end
            assign flat_w[g*RES_W +: RES_W] = word_q;
        end
    endgenerate

    assign rd_data = flat_w[rd_idx*RES_W +: RES_W];
endmodule

// File: verification/acb_top_checker.sv
// assertion checker on the ports of the converter control block
`timescale 1ns/1ps
`include "acb_regs.vh"
module acb_top_checker #(
    parameter NUM_PINS = 13
) (
    input wire ref_clk,
    input wire reset_n,
    input wire [`ACB_ADDR_W-1:0] reg_addr,
    input wire [`ACB_DATA_W-1:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [`ACB_DATA_W-1:0] reg_rdata_q,
    input wire conv_start,
    input wire conv_done,
    input wire converter_on_q,
    input wire sample_req_q,
    input wire [NUM_PINS-1:0] partner_pin_config,
    input wire [NUM_PINS-1:0] pin_config_q,
    input wire [NUM_PINS-1:0] dig_in_q,
    input wire [NUM_PINS-1:0] dig_buf_en_q,
    input wire irq_q
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    wire ctl_wr = reg_wr && reg_addr == `ACB_OFF_CTRL_ONE;
    wire [NUM_PINS-1:0] both_cfg = pin_config_q & partner_pin_config;

    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata_q == 16'h0000)
        else $error("read data outside its slot");
    a_irq_rise_cause: assert property ($rose(irq_q) |-> $past(conv_done) ||
        $past(conv_done, 2) || $past(reg_wr) || $past(reg_wr, 2))
        else $error("interrupt rose without an event");
    a_irq_fall_cause: assert property ($fell(irq_q) |-> $past(reg_wr) || $past(reg_wr, 2))
        else $error("interrupt fell without a write");
    a_start_clears_sample: assert property (conv_start && !reg_wr |=> !sample_req_q)
        else $error("sample start survived a conversion start");
    a_sample_set_src: assert property ($rose(sample_req_q) |-> $past(ctl_wr && reg_wdata[1]))
        else $error("sample start set without a write");
    a_on_write_only: assert property ($changed(converter_on_q) |-> $past(ctl_wr))
        else $error("converter on changed without a write");
    a_buf_needs_cfg: assert property ((dig_buf_en_q & ~both_cfg & ~$past(both_cfg)) == 0)
        else $error("input buffer enabled without both configs");
    a_dig_in_zero: assert property ((dig_in_q & ~dig_buf_en_q & ~$past(dig_buf_en_q)
        & ~$past(dig_buf_en_q, 2)) == 0)
        else $error("digital input not zero while buffer disabled");
endmodule

bind acb_top acb_top_checker #(.NUM_PINS(NUM_PINS)) u_chk (
    .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .conv_start(conv_start),
    .conv_done(conv_done), .converter_on_q(converter_on_q), .sample_req_q(sample_req_q),
    .partner_pin_config(partner_pin_config), .pin_config_q(pin_config_q),
    .dig_in_q(dig_in_q), .dig_buf_en_q(dig_buf_en_q), .irq_q(irq_q)
);

// File: verification/acb_adc_model.sv
// behavioural converter front end issuing start and done pulses
`timescale 1ns/1ps
module acb_adc_model (
    input wire clk,
    output logic conv_start,
    output logic conv_done,
    output logic [11:0] conv_result,
    output logic [4:0] conv_channel
);
    initial begin
        conv_start = 1'b0;
        conv_done = 1'b0;
        conv_result = 12'h000;
        conv_channel = 5'h00;
    end
    // start always leads done; gap sets a prompt or slow converter
    task automatic convert(input logic [11:0] res, input int gap);
        @(posedge clk);
        conv_start <= 1'b1;
        @(posedge clk);
        conv_start <= 1'b0;
        repeat (gap) @(posedge clk);
        conv_done <= 1'b1;
        conv_result <= res;
        conv_channel <= 5'($urandom);
        @(posedge clk);
        conv_done <= 1'b0;
        // result no longer valid: inverse, never a stale copy
        conv_result <= ~res;
    endtask
endmodule

// File: verification/acb_top_test.sv
// self-checking bench of the converter control block
`timescale 1ns/1ps
`include "acb_regs.vh"
module acb_top_test;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [12:0] partner_pin_config = 13'h0000;
    logic [12:0] pad_in = 13'h0000;
    wire [15:0] reg_rdata_q;
    wire [15:0] dma_rdata;
    wire conv_start, conv_done, converter_on_q, sample_req_q, irq_q;
    wire [11:0] conv_result;
    wire [4:0] conv_channel, scan_channel_q;
    wire [12:0] pin_config_q, dig_in_q, dig_buf_en_q;
    int n_fail = 0;
    int n_tests = 0;
    int mbuf[16];
    int ntab[3] = '{15, 0, 2};
    int i, j, k, m, n, lo;
    int ch = 0;
    logic [15:0] sel, r;
    logic [12:0] cfg, par, pad;
    logic en;

    acb_top DUT (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .conv_start(conv_start), .conv_done(conv_done), .conv_result(conv_result),
        .conv_channel(conv_channel), .converter_on_q(converter_on_q),
        .sample_req_q(sample_req_q), .scan_channel_q(scan_channel_q),
        .partner_pin_config(partner_pin_config), .pin_config_q(pin_config_q),
        .pad_in(pad_in), .dig_in_q(dig_in_q), .dig_buf_en_q(dig_buf_en_q), .irq_q(irq_q));
    // single-buffer variant on the same bus and converter, read data kept apart
    acb_top #(.HAS_DMA(1)) DUT_DMA (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(dma_rdata),
        .conv_start(conv_start), .conv_done(conv_done), .conv_result(conv_result),
        .conv_channel(conv_channel), .converter_on_q(), .sample_req_q(), .scan_channel_q(),
        .partner_pin_config(partner_pin_config), .pin_config_q(), .pad_in(pad_in),
        .dig_in_q(), .dig_buf_en_q(), .irq_q());
    acb_adc_model u_adc (.clk(ref_clk), .conv_start(conv_start), .conv_done(conv_done),
        .conv_result(conv_result), .conv_channel(conv_channel));

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata_q, exp);
    endtask
    task automatic print_verdict;
        $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        // tests take about three hundred cycles; this allows about seventy times that
        #200000;
        n_fail++;
        print_verdict;
    end

    initial begin
        r = $urandom(79);
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'b1;
        wr(`ACB_OFF_CTRL_ONE, 16'h8000);
        u_adc.convert(12'h5a5, 1);
        wr(`ACB_OFF_CTRL_ONE, 16'h8003);
        rd(`ACB_OFF_CTRL_ONE, 16'h8003);
        chk({14'h0000, converter_on_q, sample_req_q}, 16'h0003);
        fork
            u_adc.convert(12'h3c3, 6);
            begin
                repeat (4) @(posedge ref_clk);
                rd(`ACB_OFF_CTRL_ONE, 16'h8000);
            end
        join
        repeat (5) @(posedge ref_clk);
        rd(`ACB_OFF_CTRL_ONE, 16'h8001);
        wr(`ACB_OFF_CTRL_ONE, 16'h8002);
        rd(`ACB_OFF_CTRL_ONE, 16'h8002);
        rd(8'h3c, 16'h0000);
        // full sixteen, single, and a masked round
        for (k = 0; k < 3; k++) begin
            n = ntab[k];
            en = (k != 2);
            sel = 16'($urandom) | 16'h8000;
            wr(`ACB_OFF_INT_CLEAR, 16'h0003);
            wr(`ACB_OFF_INT_ENABLE, {15'h0000, en});
            wr(`ACB_OFF_SCAN_LOW, sel);
            wr(`ACB_OFF_CTRL_TWO, 16'h0400 | 16'(n << 2));
            lo = 0;
            for (i = 15; i >= 0; i--) if (sel[i]) lo = i;
            for (i = 0; i <= n; i++) begin
                r = 16'($urandom) & 16'h0fff;
                mbuf[i] = r;
                u_adc.convert(r[11:0], 1 + $urandom % 3);
                repeat (2) @(posedge ref_clk);
                #1 chk({15'h0000, irq_q}, {15'h0000, en && i == n});
                // next selected channel above the current one, wrapping to the first
                m = ch;
                ch = lo;
                if (i != n) for (j = 15; j > m; j--) if (sel[j]) ch = j;
                chk({11'h000, scan_channel_q}, 16'(ch));
            end
            for (i = 0; i <= n; i++) begin
                rd(`ACB_OFF_RESULT_BASE + 8'(4 * i), 16'(mbuf[i]));
                chk(dma_rdata, (i == 0) ? 16'(mbuf[n]) : 16'h0000);
            end
            rd(`ACB_OFF_PTR_STATUS, 16'h0000);
            chk(dma_rdata, 16'h0000);
            rd(`ACB_OFF_INT_STATUS, 16'h0001);
            // the single buffer loses data whenever two results come without a read
            chk(dma_rdata, {14'h0000, n > 0, 1'b1});
            chk({11'h000, scan_channel_q}, 16'(lo));
        end
        wr(`ACB_OFF_INT_CLEAR, 16'h0001);
        rd(`ACB_OFF_INT_STATUS, 16'h0000);
        for (i = 0; i < 4; i++) begin
            cfg = 13'($urandom);
            par = 13'($urandom);
            pad = 13'($urandom);
            @(posedge ref_clk);
            partner_pin_config <= par;
            pad_in <= pad;
            wr(`ACB_OFF_PIN_CFG, {3'h0, cfg});
            repeat (4) @(posedge ref_clk);
            #1 chk({3'h0, dig_buf_en_q}, {3'h0, cfg & par});
            chk({3'h0, dig_in_q}, {3'h0, pad & cfg & par});
            chk({3'h0, pin_config_q}, {3'h0, cfg});
        end
        print_verdict;
    end
endmodule
